// ===== rtl/fwos_pkg.sv
// fwos_pkg: constants and types of the flash write operation sequencer
// assumes one 50 MHz clock domain and a 16-bit register write port
`default_nettype none
package fwos_pkg;
   // ----------------------------------------------------------------
   // register selection on the write port
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL0H = 4'h0;
   localparam logic [3:0] REG_MASKL  = 4'h1;
   localparam logic [3:0] REG_MASKH  = 4'h2;
   localparam logic [3:0] REG_ADDRL  = 4'h3;
   localparam logic [3:0] REG_ADDRH  = 4'h4;
   localparam logic [3:0] REG_D0L    = 4'h5;
   localparam logic [3:0] REG_D0H    = 4'h6;
   localparam logic [3:0] REG_D1L    = 4'h7;
   localparam logic [3:0] REG_D1H    = 4'h8;
   localparam logic [3:0] REG_ERR    = 4'h9;

   // ----------------------------------------------------------------
   // control word 0 high fields
   // ----------------------------------------------------------------
   localparam int BIT_MODSEL  = 7;
   localparam int BIT_PROT    = 8;
   localparam int BIT_ERASE   = 11;
   localparam int BIT_DWORD   = 12;
   localparam int BIT_WORD    = 13;
   localparam int BIT_SUSPEND = 14;
   localparam int BIT_START   = 15;
   localparam logic [15:0] OPS_MASK  = 16'h3900;
   localparam logic [15:0] CLR_RUN   = 16'h46FF; // drops ops and start
   localparam int BIT_RES_ERR = 0;              // error word position
   localparam int BIT_ADDR2   = 2;

   // op bits compressed to {word, dword, erase, prot}
   localparam logic [3:0] OP_WORD  = 4'h8;
   localparam logic [3:0] OP_DWORD = 4'h4;
   localparam logic [3:0] OP_ERASE = 4'h2;
   localparam logic [3:0] OP_PROT  = 4'h1;

   // ----------------------------------------------------------------
   // protection word addresses and store layout
   // ----------------------------------------------------------------
   localparam logic [7:0]  PROT_PAGE   = 8'h0E;
   localparam logic [15:0] PROT_WP_LO  = 16'hDFB4;
   localparam logic [15:0] PROT_AP_LO  = 16'hDFB8;
   localparam logic [15:0] PROT_DIS_LO = 16'hDFBC;
   localparam logic [1:0]  IDX_WPROT   = 2'h0;
   localparam logic [1:0]  IDX_ACCESS  = 2'h1;
   localparam logic [1:0]  IDX_DISABLE = 2'h2;
   localparam logic [1:0]  IDX_REENAB  = 2'h3;
   localparam int          BIT_ACCESS_PROT_BIT    = 0;
   localparam int          BIT_DEBUG_PROT_BIT    = 1;
   localparam logic [15:0] NV_ERASED   = 16'hFFFF;

   typedef enum logic [3:0] {
      ST_IDLE, ST_W0, ST_W1, ST_EPICK, ST_EWAIT, ST_PROT_HI,
      ST_SUSPEND_BIT_WAIT, ST_SUSPENDED, ST_DONE
   } fwos_state_t;
endpackage : fwos_pkg
`default_nettype wire

// ===== rtl/fwos_prot_if.sv
// fwos_prot_if: link between the sequencer and the protection store
// assumes both ends run on the same clock
`default_nettype none
interface fwos_prot_if;
   logic        wr;
   logic [1:0]  idx;
   logic [15:0] data;
   logic [1:0]  rd_idx;
   logic [15:0] rd_data;
   logic [15:0] wprot;
   logic        acc_on;
   logic        dbg_on;
   modport seq   (output wr, idx, data, rd_idx,
                  input  rd_data, wprot, acc_on, dbg_on);
   modport store (input  wr, idx, data, rd_idx,
                  output rd_data, wprot, acc_on, dbg_on);
endinterface : fwos_prot_if
`default_nettype wire

// ===== rtl/fwos_prot_store.sv
// fwos_prot_store: non-volatile protection words and volatile copies
// assumes synchronous active-low reset restores delivery values
`default_nettype none
module fwos_prot_store
   import fwos_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  resetn,
   fwos_prot_if.store p
);
   typedef struct packed {
      logic [3:0][15:0] nv;
      logic [3:0][15:0] vol;
      logic [15:0]      rd_data;
   } fwos_store_t;

   fwos_store_t s_r;
   fwos_store_t s_nxt;
   logic [15:0] allow_dis;

   // ----------------------------------------------------------------
   // protection programming
   // ----------------------------------------------------------------
   // zeros program both copies, ones only the volatile copy of the write and access words
   always_comb begin
      s_nxt = s_r;
      allow_dis = {s_r.nv[IDX_REENAB][14:0],
                   ~s_r.nv[IDX_ACCESS][BIT_ACCESS_PROT_BIT]
                   & ~s_r.nv[IDX_ACCESS][BIT_DEBUG_PROT_BIT]};
      if (p.wr) begin
         case (p.idx)
            IDX_DISABLE: begin
               // disable bit 0 needs both protections programmed; bit n only while re-enable bit n-1 is still erased
               s_nxt.nv[IDX_DISABLE] = s_r.nv[IDX_DISABLE]
                                     & (p.data | ~allow_dis);
               s_nxt.vol[IDX_DISABLE] = s_nxt.nv[IDX_DISABLE];
            end
            IDX_REENAB: begin
               s_nxt.nv[IDX_REENAB] = s_r.nv[IDX_REENAB]
                  & (p.data | s_r.nv[IDX_DISABLE]);
               s_nxt.vol[IDX_REENAB] = s_nxt.nv[IDX_REENAB];
            end
            default: begin
               s_nxt.nv[p.idx]  = s_r.nv[p.idx] & p.data;
               s_nxt.vol[p.idx] = p.data;
            end
         endcase
      end
      // reads show the non-volatile word, so temporary state is hidden
      s_nxt.rd_data = s_r.nv[p.rd_idx];
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_r <= '{nv: {4{NV_ERASED}}, vol: {4{NV_ERASED}},
                  rd_data: 16'h0000};
      end else begin
         s_r <= s_nxt;
      end
   end

   // protections act on the volatile copy; unequal words mean disabled
   assign p.rd_data = s_r.rd_data;
   assign p.wprot   = ~s_r.vol[IDX_WPROT];
   assign p.acc_on  = ~s_r.vol[IDX_ACCESS][BIT_ACCESS_PROT_BIT]
                      & (s_r.nv[IDX_DISABLE] == s_r.nv[IDX_REENAB]);
   assign p.dbg_on  = ~s_r.vol[IDX_ACCESS][BIT_DEBUG_PROT_BIT]
                      & (s_r.nv[IDX_DISABLE] == s_r.nv[IDX_REENAB]);
endmodule : fwos_prot_store
`default_nettype wire

// ===== rtl/fwos_seq.sv
// fwos_seq: write operation sequencer for the main and extension flash
// assumes software writes registers through reg_wr/reg_sel/reg_wdata,
// and that the flash array answers each request with one flash_done
`default_nettype none

// What this block does
// - software selects op and module, loads operands, then sets start
// - clearing the op select before start cancels; nothing is written
// - word program writes 32 bits from data word 0 at target address
// - double word writes data words 0 then 1 at consecutive words
// - double word target aligned to even word, address bit 2 ignored
// - sector erase erases every sector marked in the 32-bit mask
// - module select set targets main flash, clear targets extension
// - suspend bit write halts program or erase, no start needed
// - each erased sector's mask bit clears; mask reads zero at end
// - resume with different op bits aborts and sets resume error, except word or double word in erase suspend
// - erase and suspend bits read low; that program is not suspendable
// - set protection writes a protection word from data word 0
// - zeros to the access word enable access and debug protection
// - permanent disable and re-enable, bit by bit, at most 16 times
// - writing ones changes only the volatile copy of the write and access protection words
module fwos_seq
   import fwos_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        reg_wr,
   input  wire logic [3:0]  reg_sel,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      ctrl0_high,
   output logic [15:0]      sector_mask_low,
   output logic [15:0]      sector_mask_high,
   output logic [15:0]      error_reg,
   output logic             busy,
   output logic             erase_suspended,
   output logic             flash_req,
   output logic             flash_erase,
   output logic             flash_abort,
   output logic             main_flash_module,
   output logic [23:0]      flash_addr,
   output logic [31:0]      flash_wdata,
   output logic [4:0]       flash_sector,
   input  wire logic        flash_done,
   input  wire logic [1:0]  prot_rd_idx,
   output logic [15:0]      prot_rd_data,
   output logic [15:0]      main_wprot_active,
   output logic             access_prot_on,
   output logic             debug_prot_on
);
   typedef struct packed {
      fwos_state_t st;
      logic [15:0] ctrl0;
      logic [31:0] mask;
      logic [15:0] addr_lo;
      logic [15:0] addr_hi;
      logic [15:0] d0l;
      logic [15:0] d0h;
      logic [15:0] d1l;
      logic [15:0] d1h;
      logic [15:0] err;
      logic [3:0]  saved_ops;
      logic [3:0]  cur_ops;
      logic        suspend_bit_prog;
      logic        busy;
      logic        req;
      logic        erase;
      logic        abort;
      logic        main_mod;
      logic [23:0] addr;
      logic [31:0] wdata;
      logic [4:0]  sec;
      logic        prot_wr;
      logic [1:0]  prot_idx;
      logic [15:0] prot_data;
   } fwos_seq_t;

   fwos_seq_t   s_r;
   fwos_seq_t   s_nxt;
   logic        wr_c0;
   logic        go;
   logic        resume;
   logic        suspend_bit_hit;
   logic [3:0]  ops;
   logic [2:0]  pdec;

   fwos_prot_if prot ();

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------
   // op select bits of a control word as {word, dword, erase, prot}
   function automatic logic [3:0] op_bits(input logic [15:0] c);
      op_bits = {c[BIT_WORD], c[BIT_DWORD], c[BIT_ERASE], c[BIT_PROT]};
   endfunction

   function automatic logic one_op(input logic [3:0] o);
      one_op = (o == OP_WORD) || (o == OP_DWORD) ||
               (o == OP_ERASE) || (o == OP_PROT);
   endfunction

   // lowest marked sector; callers check for an empty mask first
   function automatic logic [4:0] low_sector(input logic [31:0] m);
      low_sector = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (m[i]) begin
            low_sector = i[4:0];
         end
      end
   endfunction

   // protection word address to {hit, store index}
   function automatic logic [2:0] prot_dec(input logic [15:0] lo,
                                           input logic [15:0] hi);
      prot_dec = 3'b000;
      if (hi[7:0] == PROT_PAGE) begin
         case (lo)
            PROT_WP_LO:  prot_dec = {1'b1, IDX_WPROT};
            PROT_AP_LO:  prot_dec = {1'b1, IDX_ACCESS};
            PROT_DIS_LO: prot_dec = {1'b1, IDX_DISABLE};
            default:     prot_dec = 3'b000;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.req = 1'b0;
      s_nxt.abort = 1'b0;
      s_nxt.prot_wr = 1'b0;
      go = 1'b0;
      resume = 1'b0;
      wr_c0 = reg_wr && (reg_sel == REG_CTRL0H);
      pdec = prot_dec(s_r.addr_lo, s_r.addr_hi);

      // register writes from software
      if (reg_wr) begin
         case (reg_sel)
            REG_CTRL0H: s_nxt.ctrl0 = reg_wdata;
            REG_MASKL:  s_nxt.mask[15:0] = reg_wdata;
            REG_MASKH:  s_nxt.mask[31:16] = reg_wdata;
            REG_ADDRL:  s_nxt.addr_lo = reg_wdata;
            REG_ADDRH:  s_nxt.addr_hi = reg_wdata;
            REG_D0L:    s_nxt.d0l = reg_wdata;
            REG_D0H:    s_nxt.d0h = reg_wdata;
            REG_D1L:    s_nxt.d1l = reg_wdata;
            REG_D1H:    s_nxt.d1h = reg_wdata;
            REG_ERR:    s_nxt.err = reg_wdata;
            default:    s_nxt.err = s_nxt.err;
         endcase
      end
      ops = op_bits(s_nxt.ctrl0);

      // suspend only reaches a running operation outside erase suspend
      suspend_bit_hit = wr_c0 && reg_wdata[BIT_SUSPEND] && !s_r.suspend_bit_prog &&
                 ((s_r.st == ST_W0) || (s_r.st == ST_W1) ||
                  (s_r.st == ST_EPICK) ||
                  (s_r.st == ST_EWAIT && !flash_done));

      if (suspend_bit_hit) begin
         s_nxt.ctrl0[BIT_START] = 1'b0;
         if (s_r.st == ST_EPICK) begin
            s_nxt.st = ST_SUSPENDED;
            s_nxt.busy = 1'b0;
         end else if (flash_done) begin
            // program step ended anyway: finish rather than suspend
            s_nxt.st = (s_r.st == ST_W0 && s_r.cur_ops == OP_DWORD) ?
                       ST_W1 : ST_DONE;
            s_nxt.ctrl0[BIT_START] = 1'b1;
            if (s_nxt.st == ST_W1) begin
               s_nxt.req = 1'b1;
               s_nxt.addr = s_r.addr | 24'h000004;
               s_nxt.wdata = {s_r.d1h, s_r.d1l};
            end
         end else begin
            s_nxt.abort = 1'b1;
            s_nxt.st = ST_SUSPEND_BIT_WAIT;
         end
      end else begin
         case (s_r.st)
            ST_IDLE: begin
               if (s_nxt.ctrl0[BIT_START]) begin
                  if (s_nxt.ctrl0[BIT_SUSPEND] || !one_op(ops)) begin
                     s_nxt.ctrl0[BIT_START] = 1'b0;
                  end else begin
                     go = 1'b1;
                  end
               end
            end
            ST_W0: begin
               if (flash_done) begin
                  if (s_r.cur_ops == OP_DWORD) begin
                     // second word at the next word address
                     s_nxt.req = 1'b1;
                     s_nxt.addr = s_r.addr | 24'h000004;
                     s_nxt.wdata = {s_r.d1h, s_r.d1l};
                     s_nxt.st = ST_W1;
                  end else begin
                     s_nxt.st = ST_DONE;
                  end
               end
            end
            ST_W1: begin
               if (flash_done) begin
                  s_nxt.st = ST_DONE;
               end
            end
            ST_EPICK: begin
               if (s_nxt.mask == 32'h00000000) begin
                  s_nxt.st = ST_DONE;
               end else begin
                  s_nxt.req = 1'b1;
                  s_nxt.erase = 1'b1;
                  s_nxt.sec = low_sector(s_nxt.mask);
                  s_nxt.st = ST_EWAIT;
               end
            end
            ST_EWAIT: begin
               if (flash_done) begin
                  // a software write in this cycle wins over the clear
                  if (!(reg_wr && (reg_sel == REG_MASKL ||
                                   reg_sel == REG_MASKH))) begin
                     s_nxt.mask[s_r.sec] = 1'b0;
                  end
                  s_nxt.st = ST_EPICK;
               end
            end
            ST_PROT_HI: begin
               // permanent re-enable word through the high data half
               s_nxt.prot_wr = 1'b1;
               s_nxt.prot_idx = IDX_REENAB;
               s_nxt.prot_data = s_r.d0h;
               s_nxt.st = ST_DONE;
            end
            ST_SUSPEND_BIT_WAIT: begin
               if (flash_done) begin
                  s_nxt.st = ST_SUSPENDED;
                  s_nxt.busy = 1'b0;
               end
            end
            ST_SUSPENDED: begin
               if (s_nxt.ctrl0[BIT_START]) begin
                  if (s_nxt.ctrl0[BIT_SUSPEND]) begin
                     s_nxt.ctrl0[BIT_START] = 1'b0;
                  end else if (ops == s_r.saved_ops) begin
                     go = 1'b1;
                     resume = 1'b1;
                  end else if (s_r.saved_ops == OP_ERASE &&
                               (ops == OP_WORD || ops == OP_DWORD)) begin
                     go = 1'b1;
                     s_nxt.suspend_bit_prog = 1'b1;
                  end else begin
                     // mismatched resume drops the held operation
                     s_nxt.err[BIT_RES_ERR] = 1'b1;
                     s_nxt.ctrl0 = s_nxt.ctrl0 & CLR_RUN;
                     s_nxt.saved_ops = 4'h0;
                     s_nxt.st = ST_IDLE;
                  end
               end
            end
            ST_DONE: begin
               s_nxt.ctrl0 = s_nxt.ctrl0 & CLR_RUN;
               s_nxt.busy = 1'b0;
               s_nxt.erase = 1'b0;
               if (s_r.suspend_bit_prog) begin
                  s_nxt.suspend_bit_prog = 1'b0;
                  s_nxt.st = ST_SUSPENDED;
               end else begin
                  s_nxt.saved_ops = 4'h0;
                  s_nxt.st = ST_IDLE;
               end
            end
            default: s_nxt.st = ST_IDLE;
         endcase
      end

      // common launch of a fresh, resumed or in-suspend operation
      if (go) begin
         s_nxt.busy = 1'b1;
         s_nxt.cur_ops = ops;
         if (!s_nxt.suspend_bit_prog && !resume) begin
            s_nxt.saved_ops = ops;
         end
         if (!resume) begin
            s_nxt.main_mod = s_nxt.ctrl0[BIT_MODSEL];
         end
         case (ops)
            OP_WORD, OP_DWORD: begin
               s_nxt.req = 1'b1;
               s_nxt.erase = 1'b0;
               s_nxt.addr = {s_nxt.addr_hi[7:0], s_nxt.addr_lo};
               if (ops == OP_DWORD) begin
                  s_nxt.addr[BIT_ADDR2] = 1'b0;
               end
               s_nxt.wdata = {s_nxt.d0h, s_nxt.d0l};
               s_nxt.st = ST_W0;
            end
            OP_ERASE: s_nxt.st = ST_EPICK;
            default: begin
               // unknown protection address completes with no effect
               s_nxt.prot_wr = pdec[2];
               s_nxt.prot_idx = pdec[1:0];
               s_nxt.prot_data = s_nxt.d0l;
               s_nxt.st = (pdec == {1'b1, IDX_DISABLE}) ?
                          ST_PROT_HI : ST_DONE;
            end
         endcase
      end

      // erase and suspend read low during a program in erase suspend
      if (s_nxt.suspend_bit_prog) begin
         s_nxt.ctrl0[BIT_SUSPEND] = 1'b0;
         s_nxt.ctrl0[BIT_ERASE] = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_r <= '{st: ST_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // protection store and outputs
   // ----------------------------------------------------------------
   fwos_prot_store u_store (
      .clk    (clk),
      .resetn (resetn),
      .p      (prot.store)
   );

   assign prot.wr           = s_r.prot_wr;
   assign prot.idx          = s_r.prot_idx;
   assign prot.data         = s_r.prot_data;
   assign prot.rd_idx       = prot_rd_idx;
   assign prot_rd_data      = prot.rd_data;
   assign main_wprot_active = prot.wprot;
   assign access_prot_on    = prot.acc_on;
   assign debug_prot_on     = prot.dbg_on;

   assign ctrl0_high        = s_r.ctrl0;
   assign sector_mask_low   = s_r.mask[15:0];
   assign sector_mask_high  = s_r.mask[31:16];
   assign error_reg         = s_r.err;
   assign busy              = s_r.busy;
   assign erase_suspended   = (s_r.st == ST_SUSPENDED) || s_r.suspend_bit_prog;
   assign flash_req         = s_r.req;
   assign flash_erase       = s_r.erase;
   assign flash_abort       = s_r.abort;
   assign main_flash_module = s_r.main_mod;
   assign flash_addr        = s_r.addr;
   assign flash_wdata       = s_r.wdata;
   assign flash_sector      = s_r.sec;
endmodule : fwos_seq
`default_nettype wire

// ===== verif/fwos_seq_assertions.sv
// fwos_seq_assertions: port-level checks of the write sequencer
// assumes one clock domain and the synchronous active-low reset
`default_nettype none
module fwos_seq_chk
   import fwos_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        reg_wr,
   input wire logic [3:0]  reg_sel,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] ctrl0_high,
   input wire logic [15:0] sector_mask_low,
   input wire logic [15:0] sector_mask_high,
   input wire logic [15:0] error_reg,
   input wire logic        busy,
   input wire logic        erase_suspended,
   input wire logic        flash_req,
   input wire logic        flash_erase,
   input wire logic        flash_abort,
   input wire logic        main_flash_module,
   input wire logic        flash_done
);
   // ----------------------------------------------------------------
   // helpers and properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire       ctl_wr = reg_wr && reg_sel == REG_CTRL0H;
   wire [5:0] mcnt   = 6'($countones({sector_mask_high, sector_mask_low}));
   // erase step end outside a suspend
   wire       estep  = flash_done && flash_erase && busy && !ctrl0_high[14];
   a_abort_cause: assert property (flash_abort |->
      $past(ctl_wr) && $past(reg_wdata[14])) else $error("abort uncaused");
   a_start_busy: assert property (ctl_wr && reg_wdata[15] && !reg_wdata[14]
      && $onehot(reg_wdata & OPS_MASK) && !busy && !erase_suspended
      |=> busy) else $error("start ignored");
   a_suspend_bit_refused: assert property (ctl_wr && reg_wdata[15] && reg_wdata[14]
      && !busy && !erase_suspended |=> !busy [*2])
      else $error("start with suspend acted on");
   a_mask_shrink: assert property (estep |=> mcnt + 6'h1 == $past(mcnt))
      else $error("mask bit not cleared");
   a_erase_next: assert property (estep && mcnt > 6'h1 |-> ##[2:3] flash_req)
      else $error("next sector not requested");
   a_prog_no_erase: assert property (flash_req && !flash_erase |->
      !ctrl0_high[11] && !ctrl0_high[14]) else $error("erase bits high");
   a_module_sel: assert property (flash_req |->
      main_flash_module == ctrl0_high[7]) else $error("wrong module");
   a_word_end: assert property (flash_done && busy && ctrl0_high[13]
      && !ctrl0_high[14] |-> ##2 !busy && (ctrl0_high & 16'hB900) == 16'h0)
      else $error("word program not closed");
   a_resume_err: assert property (ctl_wr && erase_suspended && !busy
      && reg_wdata[15] && (reg_wdata & OPS_MASK) == 16'h0100
      |=> error_reg[0]) else $error("resume error missing");
   a_req_busy: assert property (flash_req |-> busy)
      else $error("request while idle");
   c_abort: cover property (flash_abort);
   c_erase: cover property (flash_req && flash_erase);
   c_err: cover property (error_reg[0]);
endmodule // fwos_seq_chk
bind fwos_seq fwos_seq_chk u_chk (.*);
`default_nettype wire

// ===== verif/tb_fwos_seq.sv
// tb_fwos_seq: directed scenarios for the write sequencer
// assumes the array answers each request after a fixed delay
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
`define WT(c) k = 0; #1; while (k < 300 && !(c)) begin @(posedge clk); #1; \
   k++; end `CHK(c, 1'b1)
module tb_fwos_seq
   import fwos_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, resetn = 0, reg_wr = 0, flash_done = 0;
   logic [3:0]  reg_sel = 0;
   logic [15:0] reg_wdata = 0;
   logic [1:0]  prot_rd_idx = 0;
   logic [15:0] ctrl0_high, sector_mask_low, sector_mask_high, error_reg;
   logic [15:0] prot_rd_data, main_wprot_active;
   logic        busy, erase_suspended, flash_req, flash_erase, flash_abort;
   logic        main_flash_module, access_prot_on, debug_prot_on;
   logic [23:0] flash_addr;
   logic [31:0] flash_wdata;
   logic [4:0]  flash_sector;
   int          n_fail = 0, comparisons = 0, k, cnt = 0;
   fwos_seq DUT (.*);
   always #10 clk = ~clk;
   // array stand-in: one done per request, slow enough to be suspended
   always @(posedge clk) begin
      flash_done <= cnt == 1;
      if (flash_req) cnt <= 6;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   task automatic wr(input logic [3:0] s, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1;
      reg_sel <= s;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 0;
   endtask
   // wait for a request pulse; call right after a register write
   task automatic wreq;
      `WT(flash_req === 1'b1)
   endtask
   task automatic prog(input logic [15:0] op, input logic [15:0] al);
      wr(REG_CTRL0H, op);
      wr(REG_ADDRL, al);
      wr(REG_ADDRH, 16'h000C);
      wr(REG_D0L, 16'hAAAA);
      wr(REG_D0H, 16'h5555);
      wr(REG_D1L, 16'h1234);
      wr(REG_D1H, 16'h8765);
      wr(REG_CTRL0H, op | 16'h8000);
      wreq;
   endtask
   task automatic t_word_dword;
      prog(16'h2000, 16'h5554);
      `CHK({main_flash_module, flash_addr}, 25'h00C5554)
      `CHK(flash_wdata, 32'h5555AAAA)
      `WT(busy === 1'b0)
      `CHK(ctrl0_high, 16'h0000)
      prog(16'h1080, 16'h555C);
      `CHK({main_flash_module, flash_addr}, 25'h10C5558)
      `CHK(flash_wdata, 32'h5555AAAA)
      @(posedge clk);
      wreq;
      `CHK({flash_addr, flash_wdata}, 56'h0C555C87651234)
      `WT(busy === 1'b0)
   endtask
   task automatic t_erase_suspend;
      wr(REG_MASKH, 16'h0003);
      wr(REG_CTRL0H, 16'h0800);
      wr(REG_CTRL0H, 16'h8800);
      wreq;
      `CHK({flash_erase, flash_sector}, 6'h30)
      wr(REG_CTRL0H, 16'h4000);
      #1 `CHK(flash_abort, 1'b1)
      `WT(erase_suspended === 1'b1 && busy === 1'b0)
      prog(16'h2000, 16'h5554);
      `CHK(ctrl0_high & 16'h4800, 16'h0000)
      `WT(busy === 1'b0)
      `CHK(erase_suspended, 1'b1)
      wr(REG_CTRL0H, 16'h0800);
      wr(REG_CTRL0H, 16'h8800);
      `WT(busy === 1'b0)
      `CHK({sector_mask_high, sector_mask_low}, 32'h0)
   endtask
   task automatic t_refusals;
      wr(REG_MASKL, 16'h0001);
      wr(REG_CTRL0H, 16'h8800);
      wreq;
      wr(REG_CTRL0H, 16'h4000);
      `WT(erase_suspended === 1'b1)
      wr(REG_CTRL0H, 16'h8100);
      @(posedge clk) #1 `CHK({error_reg[0], busy}, 2'b10)
      wr(REG_ERR, 16'h0000);
      wr(REG_CTRL0H, 16'h2000);
      wr(REG_CTRL0H, 16'h0000);
      wr(REG_CTRL0H, 16'h8000);
      wr(REG_CTRL0H, 16'hE000);
      repeat (10) @(posedge clk) #1 `CHK({busy, flash_req}, 2'b00)
      // word program suspended mid-step, then resumed with the same op
      prog(16'h2000, 16'h5554);
      wr(REG_CTRL0H, 16'h4000);
      #1 `CHK(flash_abort, 1'b1)
      `WT(busy === 1'b0)
      wr(REG_CTRL0H, 16'hA000);
      `WT(busy === 1'b0)
      `CHK({erase_suspended, ctrl0_high}, 17'h00000)
   endtask
   task automatic prot(input logic [15:0] al, input logic [15:0] dl);
      wr(REG_CTRL0H, 16'h0100);
      wr(REG_ADDRL, al);
      wr(REG_ADDRH, 16'h000E);
      wr(REG_D0L, dl);
      wr(REG_D0H, 16'hFFFF);
      wr(REG_CTRL0H, 16'h8100);
      `WT(busy === 1'b1)
      `WT(busy === 1'b0)
   endtask
   task automatic t_protect;
      prot(16'hDFB8, 16'hFFFC);
      `CHK({access_prot_on, debug_prot_on}, 2'b11)
      prot(16'hDFBC, 16'hFFFE);
      @(posedge clk) prot_rd_idx <= 2'h2;
      @(posedge clk) #1 `CHK({access_prot_on, prot_rd_data}, 17'h0FFFE)
      prot(16'hDFB4, 16'hFFF0);
      `CHK(main_wprot_active, 16'h000F)
      prot(16'hDFB4, 16'hFFFF);
      @(posedge clk) prot_rd_idx <= 2'h0;
      @(posedge clk) #1 `CHK({main_wprot_active, prot_rd_data}, 32'hFFF0)
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1;
      t_word_dword;
      t_erase_suspend;
      t_refusals;
      t_protect;
      final_report;
   end
   // watchdog: whole run needs well under 3000 cycles
   initial begin
      #200us;
      n_fail++;
      final_report;
   end
endmodule // tb_fwos_seq
`default_nettype wire
